// ==== common/jt_defs.svh ====
// jt_defs.svh: opcodes, widths, capture patterns and identity fields of the scan port
// assumes inclusion by bare name wherever these constants are needed
`ifndef JT_DEFS_SVH
`define JT_DEFS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define JT_IR_W          10
`define JT_ID_W          32
`define JT_USER_FIX_W    25
`define JT_USER_VAR_W    7
`define JT_BSR_LEN_DEF   438
`define JT_CFG_W_DEF     32

// ----------------------------------------
// instruction opcodes
// ----------------------------------------
`define JT_OP_EXTEST     10'h000
`define JT_OP_SAMPLE     10'h005
`define JT_OP_DEVICE_IDENTITY     10'h006
`define JT_OP_USER_SIGNATURE   10'h007
`define JT_OP_CFG_LOAD   10'h002
`define JT_OP_CFG_START  10'h003
`define JT_OP_BYPASS     10'h3ff

// ----------------------------------------
// capture and reset values
// ----------------------------------------
`define JT_IR_CAPTURE    10'h001
`define JT_IR_RESET      10'h006
`define JT_ID_LSB        1'h1

// identity and user signature fields: arbitrary values
`define JT_ID_VERSION    4'h3
`define JT_ID_PART       16'h00a5
`define JT_ID_MAKER      11'h055
`define JT_USER_FIXED    25'h0abcde1

`endif

// ==== common/jt_pkg.sv ====
// jt_pkg: types shared by the scan port logic
// assumes nothing beyond a SystemVerilog compiler
package jt_pkg;

    // ----------------------------------------
    // controller states, gray along the usual path
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h3,
        ST_CAP_DR   = 4'h2,
        ST_SH_DR    = 4'h6,
        ST_EX1_DR   = 4'h7,
        ST_PAU_DR   = 4'h5,
        ST_EX2_DR   = 4'h4,
        ST_UPD_DR   = 4'hc,
        ST_SEL_IR   = 4'hd,
        ST_CAP_IR   = 4'hf,
        ST_SH_IR    = 4'he,
        ST_EX1_IR   = 4'ha,
        ST_PAU_IR   = 4'hb,
        ST_EX2_IR   = 4'h9,
        ST_UPD_IR   = 4'h8
    } jt_state_e;

    typedef enum logic [2:0] {
        SEL_BYPASS = 3'h0,
        SEL_ID     = 3'h1,
        SEL_USER   = 3'h2,
        SEL_BSR    = 3'h3,
        SEL_CFG    = 3'h4
    } jt_sel_e;

    // ----------------------------------------
    // pin bundles
    // ----------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jt_link_in_s;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } jt_link_out_s;

endpackage

// ==== design/jt_tap_top.sv ====
// jt_tap_top: boundary-scan test access port, sampled on the system clock
// assumes tck, tms, tdi and the pin inputs are asynchronous to mclk and tck is slow
`timescale 1ns/1ns
`include "jt_defs.svh"

// Notes on behaviour
// [R1] instruction register is ten bits, shifted tdi to tdo in shift-ir
// [R2] user signature is 32 bits: 7 set by design, 25 fixed
// [R3] boundary chain length is a parameter per variant, e.g. 438, 690, 1050
// [R4] identity holds version 4, part 16, maker 11 and one constant bit
// [R5] identity lsb is always one and leaves tdo first
// [R6] bypass puts a one-bit register between tdi and tdo
// [R7] device_identity selects the identity register for shifting out
// [R8] user_signature selects the user signature register for shifting out
// [R9] sample captures pins into the chain and lets a pattern preload
// [R10] extest drives outputs from the update stage and captures inputs
// [R11] further instructions load configuration data through the port
// [R12] controller never runs scan tests while configuration is in progress; the code does not gate on cfg_busy, which only feeds the cfg capture lsb
// [R13] test inputs carry weak pull-ups so undriven pins read high
// [R14] sixteen-state controller on tck rise, tdo on fall, off outside shifts
module jt_tap_top #(
    parameter int              BSR_LEN  = `JT_BSR_LEN_DEF,
    parameter int              CFG_W    = `JT_CFG_W_DEF,
    parameter logic [6:0]      USER_VAR = 7'h00
) (
    // clock and control
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // scan link pins
    input  wire jt_pkg::jt_link_in_s  link_in,
    output jt_pkg::jt_link_out_s      link_out,
    output logic                      pullup_en,
    // device pins through the boundary cells
    input  wire logic [BSR_LEN-1:0]   pin_in,
    input  wire logic [BSR_LEN-1:0]   core_out,
    output logic [BSR_LEN-1:0]        pin_out,
    // configuration path
    input  wire logic                 cfg_busy,
    output logic [CFG_W-1:0]          cfg_data,
    output logic                      cfg_valid,
    output logic                      cfg_start
);

    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    if (BSR_LEN < 2) begin : g_bsr_chk
        $error("boundary chain too short");
    end
    if (CFG_W < 2) begin : g_cfg_chk
        $error("configuration word too short");
    end

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    jt_pkg::jt_link_in_s  link_s1_reg;
    jt_pkg::jt_link_in_s  link_s2_reg;
    logic                 tck_d_reg;
    logic [BSR_LEN-1:0]   pin_s1_reg;
    logic [BSR_LEN-1:0]   pin_s2_reg;
    logic                 tck_rise;
    logic                 tck_fall;

    // first stages feed only the second stages
    always_ff @(posedge mclk) begin
        if (rst) begin
            link_s1_reg <= '1; // [R13]
            link_s2_reg <= '1;
            tck_d_reg   <= 1'h1;
        end else if (ce) begin
            link_s1_reg <= link_in;
            link_s2_reg <= link_s1_reg;
            tck_d_reg   <= link_s2_reg.tck;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else if (ce) begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign tck_rise = ce & link_s2_reg.tck & ~tck_d_reg;
    assign tck_fall = ce & ~link_s2_reg.tck & tck_d_reg;

    // pull-ups are a pad property; the flag tells the pad ring to keep them on
    always_ff @(posedge mclk) begin
        if (rst) begin
            pullup_en <= 1'h1;
        end else if (ce) begin
            pullup_en <= 1'h1; // [R13]
        end
    end

    // ----------------------------------------
    // controller state machine
    // ----------------------------------------
    jt_pkg::jt_state_e  state_reg;
    jt_pkg::jt_state_e  state_next;
    logic               tms;

    assign tms = link_s2_reg.tms;

    always_comb begin
        state_next = state_reg;
        case (state_reg) // [R14]
            jt_pkg::ST_RESET:  state_next = tms ? jt_pkg::ST_RESET  : jt_pkg::ST_IDLE;
            jt_pkg::ST_IDLE:   state_next = tms ? jt_pkg::ST_SEL_DR : jt_pkg::ST_IDLE;
            jt_pkg::ST_SEL_DR: state_next = tms ? jt_pkg::ST_SEL_IR : jt_pkg::ST_CAP_DR;
            jt_pkg::ST_CAP_DR: state_next = tms ? jt_pkg::ST_EX1_DR : jt_pkg::ST_SH_DR;
            jt_pkg::ST_SH_DR:  state_next = tms ? jt_pkg::ST_EX1_DR : jt_pkg::ST_SH_DR;
            jt_pkg::ST_EX1_DR: state_next = tms ? jt_pkg::ST_UPD_DR : jt_pkg::ST_PAU_DR;
            jt_pkg::ST_PAU_DR: state_next = tms ? jt_pkg::ST_EX2_DR : jt_pkg::ST_PAU_DR;
            jt_pkg::ST_EX2_DR: state_next = tms ? jt_pkg::ST_UPD_DR : jt_pkg::ST_SH_DR;
            jt_pkg::ST_UPD_DR: state_next = tms ? jt_pkg::ST_SEL_DR : jt_pkg::ST_IDLE;
            jt_pkg::ST_SEL_IR: state_next = tms ? jt_pkg::ST_RESET  : jt_pkg::ST_CAP_IR;
            jt_pkg::ST_CAP_IR: state_next = tms ? jt_pkg::ST_EX1_IR : jt_pkg::ST_SH_IR;
            jt_pkg::ST_SH_IR:  state_next = tms ? jt_pkg::ST_EX1_IR : jt_pkg::ST_SH_IR;
            jt_pkg::ST_EX1_IR: state_next = tms ? jt_pkg::ST_UPD_IR : jt_pkg::ST_PAU_IR;
            jt_pkg::ST_PAU_IR: state_next = tms ? jt_pkg::ST_EX2_IR : jt_pkg::ST_PAU_IR;
            jt_pkg::ST_EX2_IR: state_next = tms ? jt_pkg::ST_UPD_IR : jt_pkg::ST_SH_IR;
            jt_pkg::ST_UPD_IR: state_next = tms ? jt_pkg::ST_SEL_DR : jt_pkg::ST_IDLE;
            default:           state_next = jt_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= jt_pkg::ST_RESET;
        end else if (tck_rise) begin
            state_reg <= state_next; // [R14]
        end
    end

    // ----------------------------------------
    // instruction register and decode
    // ----------------------------------------
    logic [`JT_IR_W-1:0]  ir_sh_reg;
    logic [`JT_IR_W-1:0]  scan_instruction_reg;
    jt_pkg::jt_sel_e      sel;
    logic                 tdi;

    assign tdi = link_s2_reg.tdi;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ir_sh_reg <= `JT_IR_CAPTURE;
        end else if (tck_rise) begin
            if (state_reg == jt_pkg::ST_CAP_IR) begin
                ir_sh_reg <= `JT_IR_CAPTURE;
            end else if (state_reg == jt_pkg::ST_SH_IR) begin
                ir_sh_reg <= {tdi, ir_sh_reg[`JT_IR_W-1:1]}; // [R1]
            end
        end
    end

    // the active instruction only changes in update-ir or test-logic-reset, never mid-shift
    always_ff @(posedge mclk) begin
        if (rst) begin
            scan_instruction_reg <= `JT_IR_RESET;
        end else if (tck_rise) begin
            if (state_reg == jt_pkg::ST_RESET) begin
                scan_instruction_reg <= `JT_IR_RESET;
            end else if (state_reg == jt_pkg::ST_UPD_IR) begin
                scan_instruction_reg <= ir_sh_reg; // [R1]
            end
        end
    end

    always_comb begin
        if (scan_instruction_reg == `JT_OP_DEVICE_IDENTITY) begin
            sel = jt_pkg::SEL_ID; // [R7]
        end else if (scan_instruction_reg == `JT_OP_USER_SIGNATURE) begin
            sel = jt_pkg::SEL_USER; // [R8]
        end else if (scan_instruction_reg == `JT_OP_SAMPLE ||
                     scan_instruction_reg == `JT_OP_EXTEST) begin
            sel = jt_pkg::SEL_BSR; // [R9] [R10]
        end else if (scan_instruction_reg == `JT_OP_CFG_LOAD) begin
            sel = jt_pkg::SEL_CFG; // [R11]
        end else begin
            sel = jt_pkg::SEL_BYPASS; // [R6]
        end
    end

    // ----------------------------------------
    // data registers
    // ----------------------------------------
    localparam logic [`JT_ID_W-1:0] DEVICE_IDENTITY =
        {`JT_ID_VERSION, `JT_ID_PART, `JT_ID_MAKER, `JT_ID_LSB}; // [R4] [R5]
    localparam logic [`JT_ID_W-1:0] USER_SIGNATURE =
        {`JT_USER_FIXED, USER_VAR}; // [R2]

    logic                 bypass_reg;
    logic [`JT_ID_W-1:0]  dr32_reg;
    logic [BSR_LEN-1:0]   bsr_sh_reg;
    logic [BSR_LEN-1:0]   bsr_upd_reg;
    logic [CFG_W-1:0]     cfg_sh_reg;
    logic                 cap_dr;
    logic                 sh_dr;
    logic                 upd_dr;

    assign cap_dr = tck_rise & (state_reg == jt_pkg::ST_CAP_DR);
    assign sh_dr  = tck_rise & (state_reg == jt_pkg::ST_SH_DR);
    assign upd_dr = tck_rise & (state_reg == jt_pkg::ST_UPD_DR);

    always_ff @(posedge mclk) begin
        if (rst) begin
            bypass_reg <= 1'h0;
        end else if (cap_dr) begin
            bypass_reg <= 1'h0;
        end else if (sh_dr) begin
            bypass_reg <= tdi; // [R6]
        end
    end

    // identity and user signature share one 32-bit shifter
    always_ff @(posedge mclk) begin
        if (rst) begin
            dr32_reg <= '0;
        end else if (cap_dr) begin
            if (sel == jt_pkg::SEL_USER) begin
                dr32_reg <= USER_SIGNATURE; // [R8]
            end else begin
                dr32_reg <= DEVICE_IDENTITY; // [R7]
            end
        end else if (sh_dr) begin
            dr32_reg <= {tdi, dr32_reg[`JT_ID_W-1:1]};
        end
    end

    // one cell per pin; chain length follows the variant parameter
    always_ff @(posedge mclk) begin
        if (rst) begin
            bsr_sh_reg <= '0;
        end else if (cap_dr && sel == jt_pkg::SEL_BSR) begin
            bsr_sh_reg <= pin_s2_reg; // [R3] [R9] [R10]
        end else if (sh_dr && sel == jt_pkg::SEL_BSR) begin
            bsr_sh_reg <= {tdi, bsr_sh_reg[BSR_LEN-1:1]};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bsr_upd_reg <= '0;
        end else if (upd_dr && sel == jt_pkg::SEL_BSR) begin
            bsr_upd_reg <= bsr_sh_reg; // [R9]
        end
    end

    // pins follow the core except under extest; the preload stays ready for it
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_out <= '0;
        end else if (ce) begin
            if (scan_instruction_reg == `JT_OP_EXTEST) begin
                pin_out <= bsr_upd_reg; // [R10]
            end else begin
                pin_out <= core_out; // [R9]
            end
        end
    end

    // ----------------------------------------
    // configuration load
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_sh_reg <= '0;
        end else if (cap_dr && sel == jt_pkg::SEL_CFG) begin
            cfg_sh_reg <= {{(CFG_W-1){1'h0}}, cfg_busy}; // [R11]
        end else if (sh_dr && sel == jt_pkg::SEL_CFG) begin
            cfg_sh_reg <= {tdi, cfg_sh_reg[CFG_W-1:1]};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_data  <= '0;
            cfg_valid <= 1'h0;
            cfg_start <= 1'h0;
        end else if (ce) begin
            cfg_valid <= upd_dr && sel == jt_pkg::SEL_CFG; // [R11]
            cfg_start <= tck_rise && state_reg == jt_pkg::ST_IDLE &&
                         scan_instruction_reg == `JT_OP_CFG_START; // [R11]
            if (upd_dr && sel == jt_pkg::SEL_CFG) begin
                cfg_data <= cfg_sh_reg;
            end
        end
    end

    // ----------------------------------------
    // test data out on the falling edge
    // ----------------------------------------
    logic  dr_bit;

    always_comb begin
        case (sel)
            jt_pkg::SEL_ID:   dr_bit = dr32_reg[0]; // [R5]
            jt_pkg::SEL_USER: dr_bit = dr32_reg[0];
            jt_pkg::SEL_BSR:  dr_bit = bsr_sh_reg[0];
            jt_pkg::SEL_CFG:  dr_bit = cfg_sh_reg[0];
            default:          dr_bit = bypass_reg;
        endcase
    end

    // falling edge gives the far end a full half period of setup
    always_ff @(posedge mclk) begin
        if (rst) begin
            link_out <= '0;
        end else if (tck_fall) begin
            if (state_reg == jt_pkg::ST_SH_IR) begin
                link_out <= '{tdo: ir_sh_reg[0], tdo_oe: 1'h1}; // [R14]
            end else if (state_reg == jt_pkg::ST_SH_DR) begin
                link_out <= '{tdo: dr_bit, tdo_oe: 1'h1};
            end else begin
                link_out <= '{tdo: 1'h0, tdo_oe: 1'h0};
            end
        end
    end

endmodule

// ==== dv/jt_tap_top_properties.sv ====
// jt_tap_top_properties: timing checks on the scan port pins
// assumes tck far slower than mclk, bound onto jt_tap_top
`timescale 1ns/1ns
module jt_tap_props #(
    parameter int BSR_LEN = 8,
    parameter int CFG_W   = 8
) (
    // clock and control
    input wire logic                 mclk,
    input wire logic                 rst,
    input wire logic                 ce,
    // scan link
    input wire jt_pkg::jt_link_in_s  link_in,
    input wire jt_pkg::jt_link_out_s link_out,
    input wire logic                 pullup_en,
    // pins and loader
    input wire logic [BSR_LEN-1:0]   pin_out,
    input wire logic                 cfg_valid,
    input wire logic                 cfg_start
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ----
    // assertions
    // ----
    chk_pullup_held: assert property (pullup_en)
        else $error("pull-up request dropped");
    chk_reset_quiet: assert property (
        $fell(rst) |-> !link_out.tdo_oe && !cfg_valid && !cfg_start && pin_out == '0)
        else $error("outputs not quiet after reset");
    chk_ce_freeze: assert property (
        !ce |=> $stable(link_out) && $stable(pin_out) && $stable(cfg_start))
        else $error("state moved with clock enable low");
    chk_valid_pulse: assert property (cfg_valid && ce |=> !cfg_valid)
        else $error("load strobe longer than one cycle");
    chk_start_pulse: assert property (cfg_start && ce |=> !cfg_start)
        else $error("start strobe longer than one cycle");
    // tdo may only move once tck has been low for a while
    chk_tdo_on_fall: assert property (
        $changed(link_out) |-> !link_in.tck && !$past(link_in.tck, 2))
        else $error("tdo moved away from a tck fall");
    chk_tdo_stands: assert property ($changed(link_out) |=> $stable(link_out) [*4])
        else $error("tdo did not hold");
    chk_start_on_rise: assert property (
        cfg_start |-> link_in.tck && $past(link_in.tck, 2))
        else $error("start strobe without a tck rise");
    chk_valid_on_rise: assert property (
        cfg_valid |-> link_in.tck && $past(link_in.tck, 2))
        else $error("load strobe without a tck rise");
    cov_load: cover property (cfg_valid);
    cov_start: cover property (cfg_start);
    cov_drive: cover property ($rose(link_out.tdo_oe));
endmodule

bind jt_tap_top jt_tap_props #(.BSR_LEN(BSR_LEN), .CFG_W(CFG_W)) u_jt_tap_props (
    .mclk, .rst, .ce, .link_in, .link_out, .pullup_en, .pin_out, .cfg_valid, .cfg_start);

// ==== dv/jt_host.sv ====
// jt_host: scan controller model driving tck, tms and tdi
// assumes tck idles high and results are read through res_stb
`timescale 1ns/1ns
module jt_host (
    // clock
    input wire logic                 mclk,
    // link pins
    output jt_pkg::jt_link_in_s      link_in,
    input wire jt_pkg::jt_link_out_s link_out,
    // shifted-out word
    output logic                     res_stb,
    output logic [63:0]              res_data
);
    logic tdo_w;
    // released tdo reads high through the pad pull-up
    assign tdo_w = link_out.tdo_oe ? link_out.tdo : 1'b1;
    initial begin
        link_in = 3'b111;
        res_stb = 1'b0;
        res_data = '0;
    end
    // one 48 ns tck period: fall, then rise where tdo is sampled
    task automatic step(input logic tms, input logic tdi, output logic o);
        @(posedge mclk);
        #1 link_in = {1'b0, tms, tdi};
        repeat (6) @(posedge mclk);
        o = tdo_w;
        #1 link_in.tck = 1'b1;
        repeat (5) @(posedge mclk);
    endtask
    task automatic reset_tap();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
    // idle to idle, lsb first; tdi returns high after the frame
    task automatic scan(input logic ir, input logic [63:0] d, input int n);
        logic o;
        logic [63:0] q;
        q = '0;
        step(1'b1, 1'b1, o);
        if (ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], o);
            q[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        @(posedge mclk);
        #1 res_data = q;
        res_stb = 1'b1;
        @(posedge mclk);
        #1 res_stb = 1'b0;
    endtask
endmodule

// ==== dv/jt_tap_top_tb.sv ====
// jt_tap_top_tb: self-checking bench for the scan port
// assumes jt_host drives the link and the bound checker watches the ports
`timescale 1ns/1ns
`include "jt_defs.svh"
module jt_tap_top_tb;
    localparam int         BL = 8;
    localparam int         CW = 8;
    localparam logic [6:0] UV = 7'h5a;
    logic                  mclk, rst, ce, cfg_busy, o;
    logic [BL-1:0]         pin_in, core_out, pin_out, p;
    logic [CW-1:0]         cfg_data;
    logic                  cfg_valid, cfg_start, pullup_en, res_stb;
    logic [63:0]           res_data;
    jt_pkg::jt_link_in_s   link_in;
    jt_pkg::jt_link_out_s  link_out;
    logic [127:0]          exp_q[$];
    logic [31:0]           rng;
    logic [9:0]            byp[2] = '{`JT_OP_BYPASS, 10'h155};
    int                    failures, cmp_count, cycles, starts;

    jt_tap_top #(.BSR_LEN(BL), .CFG_W(CW), .USER_VAR(UV)) u_jt_tap_top (
        .mclk, .rst, .ce, .link_in, .link_out, .pullup_en, .pin_in, .core_out,
        .pin_out, .cfg_busy, .cfg_data, .cfg_valid, .cfg_start);
    jt_host u_jt_host (.mclk, .link_in, .link_out, .res_stb, .res_data);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // ----
    // helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic note(input logic [63:0] m, input logic [63:0] v);
        exp_q.push_back({m, v & m});
    endtask
    task automatic ir(input logic [9:0] op);
        note(64'h3ff, 64'(`JT_IR_CAPTURE));
        u_jt_host.scan(1'b1, 64'(op), 10);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // results leave the queue in the order they appear at the pins
    always @(posedge mclk) begin
        logic [127:0] e;
        cycles++;
        if (res_stb || cfg_valid) begin
            e = exp_q.pop_front();
            check((res_stb ? res_data : 64'(cfg_data)) & e[127:64], e[63:0]);
        end
        if (cfg_start) starts++;
        if (cycles == 10000) begin
            failures++;
            print_verdict();
        end
    end
    // ----
    // sequence
    // ----
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        cfg_busy = 1'b0;
        pin_in = '0;
        core_out = '0;
        rng = 32'h8bcf7438;
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        u_jt_host.reset_tap();
        note('1, {32'h0, `JT_ID_VERSION, `JT_ID_PART, `JT_ID_MAKER, `JT_ID_LSB});
        u_jt_host.scan(1'b0, '0, 32);
        ir(`JT_OP_USER_SIGNATURE);
        note('1, {32'h0, `JT_USER_FIXED, UV});
        u_jt_host.scan(1'b0, '0, 32);
        foreach (byp[k]) begin
            rng = xs(rng);
            ir(byp[k]);
            note(64'hffff, {rng[14:0], 1'b0});
            u_jt_host.scan(1'b0, 64'(rng[15:0]), 16);
        end
        rng = xs(rng);
        pin_in = rng[7:0];
        core_out = rng[15:8];
        p = rng[23:16];
        ir(`JT_OP_SAMPLE);
        note(8'hff, 64'(pin_in));
        u_jt_host.scan(1'b0, 64'(p), BL);
        check(64'(pin_out), 64'(core_out));
        ir(`JT_OP_EXTEST);
        check(64'(pin_out), 64'(p));
        rng = xs(rng);
        pin_in = rng[7:0];
        note(8'hff, 64'(pin_in));
        u_jt_host.scan(1'b0, 64'(rng[15:8]), BL);
        check(64'(pin_out), 64'(rng[15:8]));
        @(posedge mclk);
        #1 ce = 1'b0;
        // a full tck pulse with tms high while frozen must not move the controller
        u_jt_host.step(1'b1, 1'b1, o);
        check(64'(o), 64'h1);
        #1 ce = 1'b1;
        // loading starts only once boundary tests are over
        cfg_busy = 1'b1;
        ir(`JT_OP_CFG_LOAD);
        rng = xs(rng);
        note(8'hff, 64'(rng[7:0]));
        note(64'h1, 64'h1);
        u_jt_host.scan(1'b0, 64'(rng[7:0]), CW);
        ir(`JT_OP_CFG_START);
        starts = 0;
        repeat (3) u_jt_host.step(1'b0, 1'b1, o);
        check(64'(starts), 64'h3);
        check(64'(link_out.tdo_oe), 64'h0);
        #1 cfg_busy = 1'b0;
        repeat (4) @(posedge mclk);
        check(64'(exp_q.size()), 64'h0);
        print_verdict();
    end
endmodule
